/* spi_periph_model.sv */
// peripheral device facing the port in controller role.
// assumes no pull on its data line, so a released line shows the inverse.
`timescale 1ns/100ps
module spi_periph_model (
	input wire logic i_sclk,
	input wire logic i_sel_n,
	input wire logic i_mosi,
	input wire logic i_pol,
	input wire logic i_pha,
	input wire logic [15:0] i_word,
	output logic o_miso,
	output logic [15:0] o_got
);
	int n = 0;
	initial o_miso = 1'b0;
	always @(negedge i_sel_n) begin
		n = 0;
		o_miso = i_word[15];
	end
	always @(posedge i_sel_n) o_miso = !o_miso;
	always @(i_sclk) begin
		if (!i_sel_n && i_sclk == (i_pol == i_pha)) begin
			o_got = {o_got[14:0], i_mosi};
			n++;
		end else if (!i_sel_n && n < 16) begin
			o_miso = i_word[15 - n];
		end
	end
endmodule

/* spi_port.sv */
// serial port core: controller or peripheral, 16-bit words.
// assumes control words are steady while a word is on the wire and that
// the peripheral host frames each word with its own select pulse.
`timescale 1ns/100ps
module spi_port
	import spi_port_pkg::*;
#(
	parameter int FIFO_WORDS = FIFO_DEPTH
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// configuration
	input wire logic [31:0] i_global_control_reg,
	input wire logic [31:0] i_format_reg,
	input wire cs_delay_reg_s i_cs_delay_reg,
	input wire logic i_select_hold_enable,
	// words to send
	input wire logic i_tx_valid,
	input wire logic [WORD_BITS-1:0] i_tx_data,
	output logic o_tx_ready,
	// words received
	output logic o_rx_valid,
	output logic [WORD_BITS-1:0] o_rx_data,
	// status
	output logic o_busy,
	// serial pins
	input wire logic i_serial_clk_pin,
	input wire logic i_sel_n,
	input wire logic i_ctrl_out_periph_in,
	input wire logic i_periph_out_ctrl_in,
	output spi_pins_s o_pins
);
	typedef enum logic [2:0] {
		IDLE, SETUP, LEAD, TRAIL, RELEASE, PERIPH
	} phase_e;

	typedef struct packed {
		phase_e fsm;
		logic [7:0] div;
		logic [7:0] wait_cnt;
		logic [4:0] bits;
		logic [WORD_BITS-1:0] shift;
		logic samp;
		logic [1:0] sclk_sync;
		logic [1:0] sel_sync;
		logic [1:0] din_sync;
		logic sclk_prev;
		logic sel_prev;
		logic rx_valid;
		logic [WORD_BITS-1:0] rx_data;
		logic busy;
		spi_pins_s pins;
	} port_state_s;

	port_state_s st, next_st;
	logic fifo_valid, fifo_ready;
	logic [WORD_BITS-1:0] fifo_data;
	logic role_ctrl, pol, pha, tick, act_rise, act_fall, pha_eq;
	logic [7:0] half;

	spi_word_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_WORDS)
	) u_tx_fifo (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_in_valid(i_tx_valid),
		.i_in_data(i_tx_data),
		.o_in_ready(o_tx_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(fifo_ready)
	);

	assign role_ctrl = i_global_control_reg[ROLE_BIT];
	assign pol = i_format_reg[POLARITY_BIT];
	assign pha = i_format_reg[PHASE_BIT];
	assign pha_eq = (pol == pha);
	// half period; a nonzero even prescale gives a longer lowhalf
	assign half = (i_format_reg[PRESCALE_MSB:PRESCALE_LSB] == 8'h00)
		? PRESCALE_ZERO_DIV
		: 8'(({1'b0, i_format_reg[PRESCALE_MSB:PRESCALE_LSB]} + 9'h001)
		>> 1);
	assign tick = (st.div == 8'h00);
	// peripheral edges on synchronised clock
	assign act_rise = st.sclk_sync[1] && !st.sclk_prev;
	assign act_fall = !st.sclk_sync[1] && st.sclk_prev;
	assign fifo_ready = (st.fsm == IDLE && role_ctrl)
		|| (st.fsm == PERIPH && st.sel_prev && !st.sel_sync[1]);

	always_comb begin
		logic [7:0] lowhalf;
		lowhalf = (i_format_reg[PRESCALE_MSB:PRESCALE_LSB] == 8'h00)
			? PRESCALE_ZERO_DIV
			: 8'(i_format_reg[PRESCALE_MSB:PRESCALE_LSB] + 8'h01 - half);
		next_st = st;
		next_st.rx_valid = 1'b0;
		next_st.sclk_sync = {st.sclk_sync[0], i_serial_clk_pin};
		next_st.sel_sync = {st.sel_sync[0], i_sel_n};
		next_st.din_sync = {st.din_sync[0],
			role_ctrl ? i_periph_out_ctrl_in : i_ctrl_out_periph_in};
		next_st.sclk_prev = st.sclk_sync[1];
		next_st.sel_prev = st.sel_sync[1];
		next_st.div = tick ? 8'h00 : st.div - 8'h01;
		next_st.pins.sclk_oe_n = !role_ctrl;
		next_st.pins.sel_oe_n = !role_ctrl;
		next_st.pins.data_oe_n = role_ctrl ? 1'b0 : st.sel_sync[1];
		next_st.busy = (st.fsm != IDLE);
		case (st.fsm)
			IDLE: begin
				next_st.pins.sclk = pol;
				next_st.pins.sel_n = 1'b1;
				if (!role_ctrl) begin
					next_st.fsm = PERIPH;
				end else if (fifo_valid) begin
					next_st.shift = fifo_data;
					next_st.pins.sel_n = 1'b0;
					next_st.bits = 5'(WORD_BITS);
					next_st.pins.data_out = fifo_data[WORD_BITS-1];
					// select to first edge: delay + 2 (3 with hold at phase 1)
					next_st.wait_cnt = i_cs_delay_reg.select_to_clock_delay
						+ ((i_select_hold_enable && pha)
						? SEL_SETUP_EXTRA_HOLD : SEL_SETUP_EXTRA)
						- 8'h01;
					next_st.fsm = SETUP;
				end
			end
			SETUP: begin
				if (st.wait_cnt != 8'h00) begin
					next_st.wait_cnt = st.wait_cnt - 8'h01;
				end else begin
					// plus a half period before the first edge
					next_st.div = half - 8'h01;
					next_st.fsm = pha ? LEAD : TRAIL;
					next_st.samp = 1'b1;
				end
			end
			LEAD: begin
				// phase 1: leading edge launches
				if (tick) begin
					next_st.pins.sclk = !st.pins.sclk;
					next_st.div = half - 8'h01;
					if (pha && !st.samp) begin
						next_st.pins.data_out = st.shift[WORD_BITS-1];
					end else if (!pha) begin
						next_st.shift = {st.shift[WORD_BITS-2:0],
							st.din_sync[1]};
						next_st.bits = st.bits - 5'd1;
					end
					next_st.samp = 1'b0;
					next_st.fsm = TRAIL;
				end
			end
			TRAIL: begin
				if (tick) begin
					if (pha) begin
						next_st.pins.sclk = !st.pins.sclk;
						next_st.shift = {st.shift[WORD_BITS-2:0],
							st.din_sync[1]};
						next_st.bits = st.bits - 5'd1;
						next_st.div = lowhalf - 8'h01;
						next_st.fsm = (st.bits == 5'd1) ? RELEASE : LEAD;
					end else if (st.samp) begin
						// phase 0: data already out, first edge samples
						next_st.samp = 1'b0;
						next_st.pins.sclk = !st.pins.sclk;
						next_st.shift = {st.shift[WORD_BITS-2:0],
							st.din_sync[1]};
						next_st.bits = st.bits - 5'd1;
						next_st.div = lowhalf - 8'h01;
					end else begin
						next_st.pins.sclk = !st.pins.sclk;
						next_st.div = half - 8'h01;
						next_st.pins.data_out = st.shift[WORD_BITS-1];
						next_st.fsm = (st.bits == 5'd0) ? RELEASE : TRAIL;
						if (st.bits != 5'd0) begin
							next_st.samp = 1'b1;
						end
					end
					if (next_st.fsm == RELEASE) begin
						next_st.wait_cnt =
							i_cs_delay_reg.clock_to_select_delay
							+ SEL_RELEASE_EXTRA - 8'h01;
					end
				end
			end
			RELEASE: begin
				if (st.wait_cnt != 8'h00) begin
					next_st.wait_cnt = st.wait_cnt - 8'h01;
				end else begin
					next_st.pins.sel_n = 1'b1;
					next_st.rx_valid = 1'b1;
					// all sixteen samples are already shifted in
					next_st.rx_data = st.shift;
					next_st.fsm = IDLE;
				end
			end
			PERIPH: begin
				// host frames each word and waits before clocking
				if (role_ctrl) begin
					next_st.fsm = IDLE;
				end else if (st.sel_prev && !st.sel_sync[1]) begin
					next_st.bits = 5'd0;
					next_st.shift = fifo_valid ? fifo_data : '0;
					next_st.pins.data_out = fifo_valid
						? fifo_data[WORD_BITS-1] : 1'b0;
				end else if (!st.sel_sync[1]) begin
					// sample edge: falling when pol == pha
					if (pha_eq ? act_fall : act_rise) begin
						next_st.shift = {st.shift[WORD_BITS-2:0],
							st.din_sync[1]};
						next_st.bits = st.bits + 5'd1;
						if (st.bits == 5'(WORD_BITS - 1)) begin
							next_st.rx_valid = 1'b1;
							next_st.rx_data = {st.shift[WORD_BITS-2:0],
								st.din_sync[1]};
						end
					end
					// launch edge: rising when pol == pha
					if ((pha_eq ? act_rise : act_fall)
						&& (st.bits != 5'd0 || pha)) begin
						next_st.pins.data_out = st.shift[WORD_BITS-1];
					end
				end
			end
			default: begin
				next_st.fsm = IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= '0;
			st.fsm <= IDLE;
			st.pins.sel_n <= 1'b1;
			st.pins.sclk_oe_n <= 1'b1;
			st.pins.sel_oe_n <= 1'b1;
			st.pins.data_oe_n <= 1'b1;
			st.sel_sync <= 2'b11;
			st.sel_prev <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign o_rx_valid = st.rx_valid;
	assign o_rx_data = st.rx_data;
	assign o_busy = st.busy;
	assign o_pins = st.pins;
endmodule

/* spi_port_pkg.sv */
// constants, field layouts and carrier structs for the serial port.
// assumes one 200 MHz clock and control bits driven by local logic.
package spi_port_pkg;

	localparam int WORD_BITS = 16;
	localparam int ROLE_BIT = 0;
	localparam int PHASE_BIT = 16;
	localparam int POLARITY_BIT = 17;
	localparam int PRESCALE_LSB = 8;
	localparam int PRESCALE_MSB = 15;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int MIN_SCLK_NS = 25;
	// least sclk period in clock cycles meeting the 25 ns floor, rounded up
	localparam int MIN_SCLK_CYC = (MIN_SCLK_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam logic [31:0] GLOBAL_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] FORMAT_RST = 32'h0000_0000;
	localparam logic [7:0] PRESCALE_ZERO_DIV = 8'h01;
	localparam logic [7:0] SEL_SETUP_EXTRA = 8'h02;
	localparam logic [7:0] SEL_SETUP_EXTRA_HOLD = 8'h03;
	localparam logic [7:0] SEL_RELEASE_EXTRA = 8'h01;
	localparam int FIFO_DEPTH = 16;

	// delay register fields
	typedef struct packed {
		logic [7:0] select_to_clock_delay;
		logic [7:0] clock_to_select_delay;
	} cs_delay_reg_s;

	// serial pin group
	typedef struct packed {
		logic sclk;
		logic sclk_oe_n;
		logic sel_n;
		logic sel_oe_n;
		logic data_out;
		logic data_oe_n;
	} spi_pins_s;

endpackage

/* spi_port_properties.sv */
// assertions on the serial port pins and receive strobe.
// assumes control words stay steady while a word is on the wire.
`timescale 1ns/100ps
module spi_port_properties
	import spi_port_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [31:0] i_global_control_reg,
	input wire logic [31:0] i_format_reg,
	input wire cs_delay_reg_s i_cs_delay_reg,
	input wire logic i_select_hold_enable,
	input wire logic o_rx_valid,
	input wire spi_pins_s o_pins
);
	logic ctl;
	logic [8:0] per, hc, sc, ne;
	assign ctl = i_global_control_reg[ROLE_BIT];
	assign per = i_format_reg[PRESCALE_MSB:PRESCALE_LSB] == 8'h00 ? 9'h002
		: i_format_reg[PRESCALE_MSB:PRESCALE_LSB] + 9'h001;
	// hc: cycles at this clock level, ne: clock edges in this frame
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			{hc, sc, ne} <= '0;
		end else begin
			hc <= $changed(o_pins.sclk) ? 9'h001 : hc + 9'h001;
			sc <= $fell(o_pins.sel_n) ? 9'h001 : sc + 9'h001;
			ne <= o_pins.sel_n ? 9'h000 : ne + 9'($changed(o_pins.sclk));
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_edge; ctl && !o_pins.sel_n && $changed(o_pins.sclk); endsequence
	sequence s_end; ctl && $rose(o_pins.sel_n); endsequence
	a_half_period: assert property (s_edge ##0 ne != 9'h000
		|-> hc == ($past(o_pins.sclk) ? per - per / 2 : per / 2))
		else $error("clock half period");
	a_first_edge: assert property (s_edge ##0 ne == 9'h000
		|-> sc == per / 2 + i_cs_delay_reg.select_to_clock_delay + 2
		+ (i_select_hold_enable && i_format_reg[PHASE_BIT]))
		else $error("select to clock delay");
	a_release_gap: assert property (s_end
		|-> hc == i_cs_delay_reg.clock_to_select_delay + 1)
		else $error("clock to select delay");
	a_bit_count: assert property (s_end |-> ne == 9'h020)
		else $error("edge count");
	a_select_gap: assert property (s_end |=> o_pins.sel_n)
		else $error("no select gap");
	a_rx_pulse: assert property (o_rx_valid |=> !o_rx_valid)
		else $error("long receive strobe");
	a_idle_level: assert property (ctl && o_pins.sel_n
		&& $past(i_nrst, 2) && $stable(i_format_reg)
		|-> o_pins.sclk == i_format_reg[POLARITY_BIT])
		else $error("idle clock level");
	a_role_release: assert property (!ctl
		&& $stable(i_global_control_reg)
		|-> o_pins.sclk_oe_n && o_pins.sel_oe_n)
		else $error("peripheral drives clock");
endmodule
bind spi_port spi_port_properties chk (.i_clk, .i_nrst, .i_global_control_reg,
	.i_format_reg, .i_cs_delay_reg, .i_select_hold_enable, .o_rx_valid, .o_pins);

/* spi_port_tb.sv */
// bench: controller words against the peripheral model, then host frames.
// assumes the port package and the peripheral model file.
`timescale 1ns/100ps
module spi_port_tb;
	import spi_port_pkg::*;
	logic i_clk, i_nrst, hold, tv, hsclk, hsel_n, hmosi, miso, rdy, rv;
	logic [31:0] gc, fm;
	logic [15:0] td, rd, pw, got;
	cs_delay_reg_s dl;
	spi_pins_s pins;
	int mismatches, checks_done, cycles;
	spi_port dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_global_control_reg(gc),
		.i_format_reg(fm), .i_cs_delay_reg(dl), .i_select_hold_enable(hold),
		.i_tx_valid(tv), .i_tx_data(td), .o_tx_ready(rdy), .o_rx_valid(rv),
		.o_rx_data(rd), .o_busy(), .o_pins(pins),
		.i_serial_clk_pin(pins.sclk_oe_n ? hsclk : pins.sclk),
		.i_sel_n(pins.sel_oe_n ? hsel_n : pins.sel_n),
		.i_ctrl_out_periph_in(hmosi), .i_periph_out_ctrl_in(miso));
	spi_periph_model peer (.i_sclk(pins.sclk), .i_sel_n(pins.sel_n),
		.i_mosi(pins.data_out), .i_pol(fm[POLARITY_BIT]),
		.i_pha(fm[PHASE_BIT]), .i_word(pw), .o_miso(miso), .o_got(got));
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = !i_clk;
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e)
			$display("BAD %0t %h %h", $time, g, e);
		if (g !== e)
			mismatches++;
	endtask
	task automatic test_done();
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic push(input logic [15:0] w);
		@(negedge i_clk);
		tv = 1'b1;
		td = w;
		while (!rdy) @(negedge i_clk);
		@(negedge i_clk);
		tv = 1'b0;
	endtask
	task automatic ctrl_word(input logic [7:0] ps, input logic [1:0] pp,
		input logic h, input logic [15:0] w);
		@(negedge i_clk);
		gc = 32'h0000_0001;
		fm = {14'h0000, pp, ps, 8'h00};
		dl = {ps ^ 8'h03, ps};
		hold = h;
		pw = ~w;
		push(w);
		repeat (400) begin
			@(negedge i_clk);
			if (rv)
				break;
		end
		cmp(rd, ~w);
		cmp(got, w);
		repeat (3) @(negedge i_clk);
	endtask
	// phase 1 only: the first host edge is then a sample edge
	task automatic host_word(input logic pol, input logic [15:0] w,
		input logic [15:0] mo);
		logic [15:0] seen, mi;
		mi = mo;
		fm = {14'h0000, pol, 1'b1, 16'h0000};
		hsclk = pol;
		repeat (4) @(negedge i_clk);
		hsel_n = 1'b0;
		hmosi = mi[15];
		repeat (24) @(negedge i_clk);
		for (int b = 15; b >= 0; b--) begin
			seen[b] = pins.data_out;
			hsclk = !pol;
			repeat (6) @(negedge i_clk);
			hsclk = pol;
			mi = mi << 1;
			hmosi = mi[15];
			repeat (6) @(negedge i_clk);
		end
		hsel_n = 1'b1;
		repeat (6) @(negedge i_clk);
		cmp(seen, w);
		cmp(rd, mo);
	endtask
	initial begin
		{i_nrst, hold, tv, hsclk, hmosi, gc, fm, dl, td, pw} = '0;
		hsel_n = 1'b1;
		{mismatches, checks_done, cycles} = '0;
		repeat (8) @(negedge i_clk);
		i_nrst = 1'b1;
		ctrl_word(8'h05, 2'b00, 1'b0, 16'h8001);
		ctrl_word(8'h05, 2'b01, 1'b1, 16'h7ffe);
		ctrl_word(8'h07, 2'b10, 1'b0, 16'ha5c3);
		ctrl_word(8'h09, 2'b11, 1'b1, 16'h3c5a);
		gc = 32'h0000_0000;
		for (int i = 0; i < 16; i++)
			push({i[3:0], 12'h0f0});
		cmp({15'h0000, rdy}, 16'h0000);
		for (int i = 0; i < 16; i++)
			host_word(i[0], {i[3:0], 12'h0f0}, {12'h5a3, i[3:0]});
		cmp({15'h0000, rdy}, 16'h0001);
		test_done();
	end
endmodule

/* spi_word_fifo.sv */
// synchronous word fifo with valid/ready on both sides.
// assumes a single clock; full and empty are exact.
`timescale 1ns/100ps
module spi_word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// fill side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// drain side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} fifo_state_s;

	fifo_state_s st, next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	// count is one bit wider than the pointers so a full fifo is visible
	assign o_in_ready = (st.count != (AW+1)'(DEPTH));
	assign o_out_valid = (st.count != '0);
	assign o_out_data = mem[st.rd];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
		end
		if (push && !pop) begin
			next_st.count = st.count + 1'b1;
		end else if (pop && !push) begin
			next_st.count = st.count - 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// storage needs no reset; reads only reach written words
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[st.wr] <= i_in_data;
		end
	end
endmodule
